// ### psg_core.sv
`include "psg_consts.svh"
`timescale 1ns/1ps
`default_nettype none

// ********************************************************
// Sample FIFO
// ********************************************************
module psg_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	input  wire logic             core_clk_i,
	input  wire logic             sys_rst_i,
	input  wire logic             in_valid_i,
	output logic                  in_ready_o,
	input  wire logic [WIDTH-1:0] in_data_i,
	output logic                  out_valid_o,
	input  wire logic             out_ready_i,
	output logic      [WIDTH-1:0] out_data_o
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_q [DEPTH];  // Sample storage
	logic [AW-1:0]    wr_q;           // Write pointer
	logic [AW-1:0]    rd_q;           // Read pointer
	logic [AW:0]      cnt_q;          // Words held
	wire              push;
	wire              pop;

	assign in_ready_o  = (cnt_q != (AW+1)'(DEPTH));
	assign out_valid_o = (cnt_q != '0);
	assign push        = in_valid_i & in_ready_o;
	assign pop         = out_valid_o & out_ready_i;
	assign out_data_o  = mem_q[rd_q];

	// Storage write, no reset needed
	always_ff @(posedge core_clk_i) begin
		if (push) begin
			mem_q[wr_q] <= in_data_i;
		end
	end

	// Pointers and occupancy
	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			wr_q  <= '0;
			rd_q  <= '0;
			cnt_q <= '0;
		end else begin
			wr_q  <= push ? AW'(wr_q + 1'b1) : wr_q;
			rd_q  <= pop ? AW'(rd_q + 1'b1) : rd_q;
			cnt_q <= (AW+1)'(cnt_q + push - pop);
		end
	end
endmodule

// ********************************************************
// Sound generator top
// ********************************************************
// Functional notes
// R1: Both lines high latch register number
// R2: Direction high, control low writes latched register
// R3: Always selected, no chip select decoding
// R4: Single clock, synchronous reset everywhere except FIFO storage
// R5: Parallel 8-bit digital audio output
// R6: Pulse-width modulated single-bit audio output
// R7: Three channels summed into master output
// R8: Channel waveforms swing 0/1, no offset
// R9: Even register low byte, odd high nibble
// R10: Register seven tone/noise disable bits
// R11: Level low nibble, bit four selects envelope
// R12: Envelope period from low and high bytes
// R13: Shape bits continue, attack, alternate, hold
// R14: Equal selects divide clock by eight
// R15: Select low only bypasses prescaler
// R16: Select high only divides by 128
// R17: Latch takes low four bus bits
// R18: Host drives bus, control, selects on pins
// R19: Channel PWM on bidirectional pins four-six
// R20: Master PWM on last bidirectional pin
// R21: Tone counter toggles output at period
// R22: 17-bit LFSR noise, 5-bit rate counter
// R23: Shared envelope, 16-bit rate, ten shapes
// R24: Exactly fourteen registers numbered from zero
// R25: Held write state rewrites same value
module psg_core #(
	parameter int FIFO_DEPTH = 16
) (
	input  wire logic       core_clk_i,
	input  wire logic       sys_rst_i,
	input  wire logic [7:0] muxed_bus_bits_i,
	input  wire logic [7:0] bidir_in_i,
	output logic      [7:0] bidir_out_o,
	output logic      [7:0] bidir_oe_o,
	output logic      [7:0] digital_audio_o,
	output logic            audio_pwm_o
);

	// ********************************************************
	// Pin synchronisers
	// ********************************************************
	logic [7:0] bus_s1_q;   // First stage, bus bits
	logic [7:0] bus_s2_q;   // Second stage, bus bits
	logic [3:0] ctl_s1_q;   // First stage, control pins
	logic [3:0] ctl_s2_q;   // Second stage, control pins

	// Two flip-flops before any logic reads a pin
	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			bus_s1_q <= 8'h00;
			bus_s2_q <= 8'h00;
			ctl_s1_q <= 4'h0;
			ctl_s2_q <= 4'h0;
		end else begin
			bus_s1_q <= muxed_bus_bits_i;  // R18
			bus_s2_q <= bus_s1_q;
			ctl_s1_q <= bidir_in_i[3:0];   // R18
			ctl_s2_q <= ctl_s1_q;
		end
	end

	wire bus_control_line   = ctl_s2_q[`PSG_PIN_BUS_CTL];
	wire bus_direction_line = ctl_s2_q[`PSG_PIN_BUS_DIR];
	wire clock_select_low   = ctl_s2_q[`PSG_PIN_SEL_LO];
	wire clock_select_high  = ctl_s2_q[`PSG_PIN_SEL_HI];

	// ********************************************************
	// Host bus decode and register file
	// ********************************************************
	psg_pkg::psg_bus_op_t bus_op;  // Decoded bus operation
	logic [3:0] addr_q;            // Latched register number
	logic [7:0] regs_q [`PSG_REG_COUNT];  // Register file
	wire        wr_shape;          // Write to the shape register

	// No select qualifier: every bus state is decoded
	assign bus_op = psg_pkg::psg_bus_op_t'({bus_direction_line, bus_control_line});  // R3
	assign wr_shape = (bus_op == psg_pkg::PSG_BUS_WRITE) && (addr_q == `PSG_REG_ENV_SHAPE);

	// Address latch
	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			addr_q <= 4'h0;  // R4
		end else if (bus_op == psg_pkg::PSG_BUS_LATCH) begin
			addr_q <= bus_s2_q[3:0];  // R1 R17
		end
	end

	// Register writes; numbers above thirteen are dropped
	genvar gr;
	generate
		for (gr = 0; gr < `PSG_REG_COUNT; gr++) begin : g_reg
			always_ff @(posedge core_clk_i) begin
				if (sys_rst_i) begin
					regs_q[gr] <= `PSG_REG_RESET;  // R4
				end else if (bus_op == psg_pkg::PSG_BUS_WRITE && addr_q == 4'(gr)) begin
					regs_q[gr] <= bus_s2_q;  // R2 R24 R25
				end
			end
		end
	endgenerate

	// ********************************************************
	// Prescaler
	// ********************************************************
	psg_pkg::psg_div_t div_sel;  // Selected ratio
	logic [6:0] pre_q;            // Free running prescale count
	wire        tick;             // Generator step enable

	// Ratio from the two select inputs
	assign div_sel = (clock_select_low == clock_select_high) ? psg_pkg::PSG_DIV_8 :   // R14
	                 clock_select_low ? psg_pkg::PSG_DIV_1 : psg_pkg::PSG_DIV_128;    // R15 R16
	assign tick = (div_sel == psg_pkg::PSG_DIV_1) ||                                   // R15
	              (div_sel == psg_pkg::PSG_DIV_8 &&
	               (pre_q & `PSG_DIV_STD_MASK) == `PSG_DIV_STD_MASK) ||                  // R14
	              (div_sel == psg_pkg::PSG_DIV_128 && pre_q == `PSG_DIV_SLOW_MASK);    // R16

	// Prescale counter
	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			pre_q <= 7'h00;
		end else begin
			pre_q <= 7'(pre_q + 1'b1);
		end
	end

	// ********************************************************
	// Tone generators
	// ********************************************************
	logic [2:0] tone_q;  // Square outputs A..C

	genvar gt;
	generate
		for (gt = 0; gt < 3; gt++) begin : g_tone
			logic [11:0] cnt_q;   // Up counter
			wire  [11:0] period;  // 12-bit tone period
			assign period = {regs_q[2*gt+1][3:0], regs_q[2*gt]};  // R9
			// Count up, restart and flip at the period
			always_ff @(posedge core_clk_i) begin
				if (sys_rst_i) begin
					cnt_q      <= 12'h000;
					tone_q[gt] <= 1'b0;
				end else if (tick) begin
					if (cnt_q >= period) begin
						cnt_q      <= 12'h000;     // R21
						tone_q[gt] <= ~tone_q[gt];  // R21
					end else begin
						cnt_q <= 12'(cnt_q + 1'b1);
					end
				end
			end
		end
	endgenerate

	// ********************************************************
	// Noise generator
	// ********************************************************
	logic [4:0]  ncnt_q;  // Shift rate counter
	logic [16:0] lfsr_q;  // Noise shift register
	wire  [4:0]  nper;    // Noise period
	wire         noise;   // Noise bit

	assign nper  = regs_q[`PSG_REG_NOISE_PER][4:0];
	assign noise = lfsr_q[0];

	// Shift the register each time the rate counter expires
	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			ncnt_q <= 5'h00;
			lfsr_q <= `PSG_LFSR_SEED;
		end else if (tick) begin
			if (ncnt_q >= nper) begin
				ncnt_q <= 5'h00;                               // R22
				lfsr_q <= {lfsr_q[0] ^ lfsr_q[3], lfsr_q[16:1]};  // R22
			end else begin
				ncnt_q <= 5'(ncnt_q + 1'b1);
			end
		end
	end

	// ********************************************************
	// Envelope generator
	// ********************************************************
	logic [15:0] ecnt_q;    // Step rate counter
	logic [3:0]  estep_q;   // Step within a ramp
	logic        eup_q;     // Ramp rising
	logic        eheld_q;   // Ramp frozen
	wire  [15:0] eper;      // Envelope period
	wire  [3:0]  shape;     // Shape control bits
	wire  [3:0]  env_lvl;   // Shared envelope level
	wire         estep_en;  // Advance one step

	assign eper     = {regs_q[`PSG_REG_ENV_HI], regs_q[`PSG_REG_ENV_LO]};  // R12
	assign shape    = regs_q[`PSG_REG_ENV_SHAPE][3:0];
	assign env_lvl  = eup_q ? estep_q : ~estep_q;
	assign estep_en = tick && (ecnt_q >= eper);

	// Rate counter
	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i || wr_shape) begin
			ecnt_q <= 16'h0000;
		end else if (tick) begin
			ecnt_q <= estep_en ? 16'h0000 : 16'(ecnt_q + 1'b1);  // R23
		end
	end

	// Ramp sequencing; a shape write restarts the envelope
	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			estep_q <= 4'h0;
			eup_q   <= 1'b0;
			eheld_q <= 1'b1;
		end else if (wr_shape) begin
			estep_q <= 4'h0;
			eup_q   <= bus_s2_q[`PSG_SHP_ATTACK];  // R13
			eheld_q <= 1'b0;
		end else if (estep_en && !eheld_q) begin
			if (estep_q != 4'hf) begin
				estep_q <= 4'(estep_q + 1'b1);
			end else if (!shape[`PSG_SHP_CONTINUE]) begin
				eup_q   <= 1'b0;  // R13
				eheld_q <= 1'b1;
			end else if (shape[`PSG_SHP_HOLD]) begin
				eup_q   <= eup_q ^ shape[`PSG_SHP_ALTERNATE];  // R13
				eheld_q <= 1'b1;
			end else begin
				estep_q <= 4'h0;
				eup_q   <= eup_q ^ shape[`PSG_SHP_ALTERNATE];  // R13 R23
			end
		end
	end

	// ********************************************************
	// Mixer and channel levels
	// ********************************************************
	logic [3:0] lvl_q [3];  // Channel output levels
	logic [5:0] sum;        // Sum of three channels

	genvar gm;
	generate
		for (gm = 0; gm < 3; gm++) begin : g_mix
			wire [7:0] vol = regs_q[`PSG_REG_LEVEL_A + gm];
			wire       on  = (tone_q[gm] | regs_q[`PSG_REG_MIXER][gm]) &                        // R10
			                 (noise | regs_q[`PSG_REG_MIXER][`PSG_MIX_NOISE_LSB + gm]);          // R10
			wire [3:0] amp = vol[`PSG_LVL_ENV_BIT] ? env_lvl : vol[3:0];                         // R11
			// Gated level, zero when off
			always_ff @(posedge core_clk_i) begin
				if (sys_rst_i) begin
					lvl_q[gm] <= 4'h0;
				end else begin
					lvl_q[gm] <= on ? amp : 4'h0;  // R8
				end
			end
		end
	endgenerate

	assign sum = 6'(lvl_q[0]) + 6'(lvl_q[1]) + 6'(lvl_q[2]);  // R7

	// ********************************************************
	// Sample path through the FIFO
	// ********************************************************
	logic [7:0] samp_cnt_q;  // Sample period count
	logic [7:0] pwm_q;       // PWM ramp
	logic [7:0] master_q;    // Sample now playing
	wire  [7:0] samp;        // Scaled sum, 0..225
	wire        push_v;      // Sample offered
	wire        in_ready;    // FIFO has room
	wire        out_valid;   // FIFO has a sample
	wire        pop;         // Take next sample
	wire  [7:0] fifo_data;   // Head of FIFO

	assign samp   = {sum, 2'b00} + {2'b00, sum};  // R5
	assign push_v = (samp_cnt_q == `PSG_SAMPLE_LAST);
	assign pop    = (pwm_q == 8'hff);

	psg_fifo #(
		.WIDTH (8),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.core_clk_i  (core_clk_i),
		.sys_rst_i   (sys_rst_i),
		.in_valid_i  (push_v),
		.in_ready_o  (in_ready),
		.in_data_i   (samp),
		.out_valid_o (out_valid),
		.out_ready_i (pop),
		.out_data_o  (fifo_data)
	);

	// Sampler stalls at the last count while the FIFO is full
	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			samp_cnt_q <= 8'h00;
		end else if (!push_v || in_ready) begin
			samp_cnt_q <= 8'(samp_cnt_q + 1'b1);
		end
	end

	// PWM ramp and playing sample; holds last sample on underrun
	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			pwm_q    <= 8'h00;
			master_q <= 8'h00;
		end else begin
			pwm_q <= 8'(pwm_q + 1'b1);
			if (pop && out_valid) begin
				master_q <= fifo_data;
			end
		end
	end

	// ********************************************************
	// Audio outputs
	// ********************************************************
	logic [3:0] pwm_ch_q;   // Per-channel PWM bits, master on top
	logic [7:0] digital_q;  // Parallel audio word

	genvar gp;
	generate
		for (gp = 0; gp < 3; gp++) begin : g_pwm
			// Level scaled by 17 onto the 8-bit ramp
			always_ff @(posedge core_clk_i) begin
				if (sys_rst_i) begin
					pwm_ch_q[gp] <= 1'b0;
				end else begin
					pwm_ch_q[gp] <= ({lvl_q[gp], lvl_q[gp]} > pwm_q);  // R6 R19
				end
			end
		end
	endgenerate

	// Master PWM and digital word from the played sample
	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			pwm_ch_q[3] <= 1'b0;
			digital_q   <= 8'h00;
		end else begin
			pwm_ch_q[3] <= (master_q > pwm_q);  // R6 R20
			digital_q   <= master_q;            // R5
		end
	end

	assign digital_audio_o = digital_q;
	assign audio_pwm_o     = pwm_ch_q[3];
	assign bidir_out_o     = {pwm_ch_q, 4'h0};  // R19 R20
	assign bidir_oe_o      = `PSG_PIN_OE;       // R19 R20

endmodule

`default_nettype wire

// ### psg_consts.svh
`ifndef PSG_CONSTS_SVH
`define PSG_CONSTS_SVH

// ********************************************************
// Register numbers
// ********************************************************
`define PSG_REG_TONE_A_LO   4'h0
`define PSG_REG_TONE_A_HI   4'h1
`define PSG_REG_TONE_B_LO   4'h2
`define PSG_REG_TONE_B_HI   4'h3
`define PSG_REG_TONE_C_LO   4'h4
`define PSG_REG_TONE_C_HI   4'h5
`define PSG_REG_NOISE_PER   4'h6
`define PSG_REG_MIXER       4'h7
`define PSG_REG_LEVEL_A     4'h8
`define PSG_REG_LEVEL_B     4'h9
`define PSG_REG_LEVEL_C     4'ha
`define PSG_REG_ENV_LO      4'hb
`define PSG_REG_ENV_HI      4'hc
`define PSG_REG_ENV_SHAPE   4'hd
`define PSG_REG_COUNT       14
`define PSG_REG_RESET       8'h00

// ********************************************************
// Field positions
// ********************************************************
`define PSG_MIX_NOISE_LSB   3
`define PSG_LVL_ENV_BIT     4
`define PSG_SHP_CONTINUE    3
`define PSG_SHP_ATTACK      2
`define PSG_SHP_ALTERNATE   1
`define PSG_SHP_HOLD        0

// ********************************************************
// Bidirectional pin positions
// ********************************************************
`define PSG_PIN_BUS_CTL     0
`define PSG_PIN_BUS_DIR     1
`define PSG_PIN_SEL_LO      2
`define PSG_PIN_SEL_HI      3
`define PSG_PIN_PWM_A       4
`define PSG_PIN_MASTER      7
`define PSG_PIN_OE          8'hf0

// ********************************************************
// Prescaler and timing counts
// ********************************************************
`define PSG_DIV_STD_MASK    7'h07
`define PSG_DIV_SLOW_MASK   7'h7f
`define PSG_LFSR_SEED       17'h00001
`define PSG_SAMPLE_LAST     8'hff

`endif

// ### psg_pkg.sv
package psg_pkg;

	// Bus operation decoded from direction and control lines
	typedef enum logic [1:0] {
		PSG_BUS_IDLE,
		PSG_BUS_UNSUPPORTED,
		PSG_BUS_WRITE,
		PSG_BUS_LATCH
	} psg_bus_op_t;

	// Prescaler ratio selected by the two select inputs
	typedef enum logic [1:0] {
		PSG_DIV_8,
		PSG_DIV_1,
		PSG_DIV_128
	} psg_div_t;

endpackage

// ### psg_core_checker.sv
`timescale 1ns/1ps
`default_nettype none

// ********************************************************
// Port checker for the sound generator
// ********************************************************
module psg_core_checker (
	input  wire logic       core_clk_i,
	input  wire logic       sys_rst_i,
	input  wire logic [7:0] muxed_bus_bits_i,
	input  wire logic [7:0] bidir_in_i,
	input  wire logic [7:0] bidir_out_o,
	input  wire logic [7:0] bidir_oe_o,
	input  wire logic [7:0] digital_audio_o,
	input  wire logic       audio_pwm_o
);
	logic [8:0] gap_q;  // Clocks since the sample word changed
	logic [8:0] hia_q;  // Run of high clocks on channel A
	logic [8:0] him_q;  // Run of high clocks on the master pin

	default clocking cb @(posedge core_clk_i);
	endclocking
	default disable iff (sys_rst_i);

	// Saturating run counters
	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			gap_q <= 9'h1ff;
			hia_q <= 9'h000;
			him_q <= 9'h000;
		end else begin
			gap_q <= $changed(digital_audio_o) ? 9'h000 : gap_q + {8'h00, gap_q != 9'h1ff};
			hia_q <= bidir_out_o[4] ? hia_q + {8'h00, hia_q != 9'h1ff} : 9'h000;
			him_q <= audio_pwm_o ? him_q + {8'h00, him_q != 9'h1ff} : 9'h000;
		end
	end

	property p_oe_fixed;
		bidir_oe_o == 8'hf0;
	endproperty
	a_oe_fixed: assert property (p_oe_fixed) else $error("pin enables wrong");

	property p_host_pins_quiet;
		bidir_out_o[3:0] == 4'h0;
	endproperty
	a_host_pins_quiet: assert property (p_host_pins_quiet) else $error("input pins driven");

	property p_master_pin;
		audio_pwm_o == bidir_out_o[7];
	endproperty
	a_master_pin: assert property (p_master_pin) else $error("master pin differs");

	property p_reset_clear;
		disable iff (1'b0) sys_rst_i |=> (digital_audio_o == 8'h00 && bidir_out_o == 8'h00);
	endproperty
	a_reset_clear: assert property (p_reset_clear) else $error("outputs not cleared");

	property p_sample_gap;
		$changed(digital_audio_o) |-> gap_q >= 9'd255;
	endproperty
	a_sample_gap: assert property (p_sample_gap) else $error("sample changed too soon");

	property p_sample_sum;
		(digital_audio_o % 8'd5) == 8'd0 && digital_audio_o <= 8'd225;
	endproperty
	a_sample_sum: assert property (p_sample_sum) else $error("sample not a level sum");

	property p_chan_swing;
		hia_q <= 9'd255;
	endproperty
	a_chan_swing: assert property (p_chan_swing) else $error("channel pwm stuck high");

	property p_master_swing;
		him_q <= 9'd226;
	endproperty
	a_master_swing: assert property (p_master_swing) else $error("master pwm too long high");
endmodule

`default_nettype wire

// ### psg_host_model.sv
`timescale 1ns/1ps
`default_nettype none

// ********************************************************
// Host controller on the multiplexed bus
// ********************************************************
module psg_host_model (
	input  wire logic       core_clk_i,
	output logic      [7:0] bus_o,
	output logic      [3:0] pins_o
);
	int         hold_n = 3;     // Clocks that each bus state stands
	logic [1:0] sel_q  = 2'b00; // Clock select pair, high then low

	// Idle bus at time zero
	initial begin
		bus_o = 8'h00;
		pins_o = 4'h0;
	end

	// One bus state {direction, control}, held, then released
	task automatic drive(input logic [1:0] st, input logic [7:0] v);
		@(negedge core_clk_i);
		bus_o = v;
		pins_o = {sel_q, st};
		repeat (hold_n) @(negedge core_clk_i);
		bus_o = ~v;                             // Released bus shows no stale value
		pins_o = {sel_q, 2'b00};
	endtask

	// Change the clock select pair
	task automatic set_sel(input logic [1:0] s);
		@(negedge core_clk_i);
		sel_q = s;
		pins_o = {s, pins_o[1:0]};
	endtask
endmodule

`default_nettype wire

// ### psg_core_tb.sv
`timescale 1ns/1ps
`default_nettype none

// ********************************************************
// Self-checking bench
// ********************************************************
module psg_core_tb;
	logic       core_clk_i = 1'b0;
	logic       sys_rst_i  = 1'b1;
	logic [7:0] host_bus;                        // Bus from the host
	logic [3:0] host_pins;                       // Control pins from the host
	logic [7:0] bidir_in;                        // Resolved pin levels
	logic [7:0] bidir_out;
	logic [7:0] bidir_oe;
	logic [7:0] digital_audio;
	logic       audio_pwm;
	int         num_errors  = 0;
	int         check_count = 0;
	int         shadow [16];                     // Reference register file
	int         latched     = 0;                 // Reference latched number
	int         env_end     = 15;                // Level the envelope rests at
	int         m;
	logic [1:0] sel_tab [4] = '{2'b01, 2'b00, 2'b11, 2'b10};
	int         half    [4] = '{4, 32, 32, 512}; // Tone half wave for period 3

	always #10 core_clk_i = ~core_clk_i;

	// Device drives enabled pins, the host the rest
	assign bidir_in = (bidir_out & bidir_oe) | ({4'h0, host_pins} & ~bidir_oe);

	psg_core #(.FIFO_DEPTH(16)) dut (
		.core_clk_i       (core_clk_i),
		.sys_rst_i        (sys_rst_i),
		.muxed_bus_bits_i (host_bus),
		.bidir_in_i       (bidir_in),
		.bidir_out_o      (bidir_out),
		.bidir_oe_o       (bidir_oe),
		.digital_audio_o  (digital_audio),
		.audio_pwm_o      (audio_pwm)
	);

	psg_host_model host (
		.core_clk_i (core_clk_i),
		.bus_o      (host_bus),
		.pins_o     (host_pins)
	);

	task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
		check_count++;
		if (got !== exp) begin
			num_errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic chk_count(input int got, input int exp);
		check_count++;
		if (got != exp) begin
			num_errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic wrap_up;
		$display("checks %0d mismatches %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	// Latch with random upper bits, then write; mirror in the reference
	task automatic put(input logic [3:0] a, input logic [7:0] d);
		logic [3:0] up;
		up = 4'($urandom);
		host.hold_n = $urandom_range(7, 3);
		host.drive(2'b11, {up, a});
		latched = int'(a);
		host.drive(2'b10, d);
		if (latched < 14) begin
			shadow[latched] = int'(d);
		end
	endtask

	// Effective level: envelope rests at full level until a shape write runs it out
	function automatic int lvl(input int ch);
		return ((shadow[8 + ch] & 16) != 0) ? env_end : (shadow[8 + ch] & 15);
	endfunction

	// Duty per channel and the summed sample word
	task automatic check_levels;
		int n;
		int w;
		repeat (8) @(posedge core_clk_i);
		for (int ch = 0; ch < 3; ch++) begin
			n = 0;
			repeat (256) begin
				@(posedge core_clk_i);
				#1;
				if (bidir_out[4 + ch] === 1'b1) n++;
			end
			chk_count(n, lvl(ch) * 17);
		end
		w = 0;
		while (digital_audio !== 8'(5 * (lvl(0) + lvl(1) + lvl(2))) && w < 6000) begin
			@(posedge core_clk_i);
			#1;
			w++;
		end
		chk_byte(digital_audio, 8'(5 * (lvl(0) + lvl(1) + lvl(2))));
		if (w >= 6000) wrap_up();
		// Master duty over one full ramp equals the sample word
		n = 0;
		repeat (256) begin
			@(posedge core_clk_i);
			#1;
			if (audio_pwm === 1'b1) n++;
		end
		chk_count(n, 5 * (lvl(0) + lvl(1) + lvl(2)));
	endtask

	// Longest low run on channel A
	task automatic low_run(output int mx);
		int r;
		mx = 0;
		r = 0;
		repeat (1200) begin
			@(posedge core_clk_i);
			#1;
			r = (bidir_out[4] === 1'b0) ? r + 1 : 0;
			if (r > mx) mx = r;
		end
	endtask

	// Main sequence
	initial begin
		void'($urandom(55156));
		for (int i = 0; i < 16; i++) shadow[i] = 0;
		repeat (20) @(negedge core_clk_i);
		sys_rst_i = 1'b0;
		chk_byte(bidir_oe, 8'hf0);
		chk_byte(digital_audio, 8'h00);
		$display("test reset done");
		put(4'h7, 8'h3f);
		for (int r = 0; r < 3; r++) begin
			for (int ch = 0; ch < 3; ch++) begin
				put(4'(8 + ch), (r == 0) ? 8'h0f : 8'($urandom_range(31, 0)));
			end
			check_levels();
		end
		$display("test levels done");
		// Unsupported state must not move the latch; 14 and 15 are absent
		put(4'h9, 8'h05);
		host.drive(2'b01, 8'h08);
		host.drive(2'b10, 8'h0c);
		shadow[9] = 8'h0c;
		put(4'he, 8'h0f);
		put(4'hf, 8'h1f);
		check_levels();
		$display("test refusals done");
		// Tone period 3 from the pair, upper nibble of the high byte unused
		put(4'h0, 8'h03);
		put(4'h1, 8'hf0);
		put(4'h8, 8'h0f);
		put(4'h7, 8'h3e);
		for (int s = 0; s < 4; s++) begin
			host.set_sel(sel_tab[s]);
			repeat (600) @(posedge core_clk_i);
			low_run(m);
			chk_count((m >= half[s] - 2 && m <= half[s] + 2) ? half[s] : m, half[s]);
		end
		$display("test prescaler done");
		// Envelope runs to its end: decay rests low, held attack rests high
		host.set_sel(2'b00);
		put(4'h7, 8'h3f);
		put(4'hb, 8'h03);
		put(4'hc, 8'h00);
		put(4'h8, 8'h10);
		put(4'hd, 8'h00);
		env_end = 0;
		repeat (700) @(posedge core_clk_i);
		check_levels();
		put(4'hd, 8'h0d);
		env_end = 15;
		repeat (700) @(posedge core_clk_i);
		check_levels();
		$display("test envelope done");
		@(negedge core_clk_i);
		sys_rst_i = 1'b1;
		repeat (3) @(negedge core_clk_i);
		chk_byte(digital_audio, 8'h00);
		chk_byte(bidir_out, 8'h00);
		sys_rst_i = 1'b0;
		for (int i = 0; i < 16; i++) shadow[i] = 0;
		latched = 0;
		env_end = 15;
		check_levels();
		$display("test second reset done");
		wrap_up();
	end
endmodule

bind psg_core psg_core_checker u_chk (
	.core_clk_i       (core_clk_i),
	.sys_rst_i        (sys_rst_i),
	.muxed_bus_bits_i (muxed_bus_bits_i),
	.bidir_in_i       (bidir_in_i),
	.bidir_out_o      (bidir_out_o),
	.bidir_oe_o       (bidir_oe_o),
	.digital_audio_o  (digital_audio_o),
	.audio_pwm_o      (audio_pwm_o)
);

`default_nettype wire
